/* inc/cci_pkg.sv */
// Shared constants and types for the core complex boundary model.
// Assumes both ends run on one system clock at 100 MHz.
package cci_pkg;
    localparam int unsigned CCI_ADDR_W       = 38;         // Physical address width.
    localparam int unsigned CCI_HARTS        = 5;          // Number of harts.
    localparam int unsigned CCI_LIRQ_W       = 48;         // Local interrupt lines per hart.
    localparam int unsigned CCI_GIRQ_W       = 508;        // Exposed global interrupt lines.
    localparam int unsigned CCI_GIRQ_TOTAL   = 511;        // All controller sources.
    localparam int unsigned CCI_NARROW_W     = 64;         // Inbound, peripheral, uncached data width.
    localparam int unsigned CCI_WIDE_W       = 128;        // Cacheable data width.
    localparam int unsigned CCI_MTIME_W      = 64;         // Real-time counter width.
    localparam int unsigned CCI_RST_CYCLES   = 16;         // Least reset length in system cycles.
    localparam int unsigned CCI_TICK_DIV     = 4;          // Host tick half period; keeps tick below clock/2.
    localparam int unsigned CCI_BOOT_ADDR    = 32'h8000_0000; // Default boot address.
    // Outbound windows: base and top of each.
    localparam logic [37:0] CCI_PER_LO_BASE  = 38'h00_2000_0000;
    localparam logic [37:0] CCI_PER_LO_TOP   = 38'h00_4fff_ffff;
    localparam logic [37:0] CCI_PER_HI_BASE  = 38'h01_0000_0000;
    localparam logic [37:0] CCI_PER_HI_TOP   = 38'h0f_ffff_ffff;
    localparam logic [37:0] CCI_UNC_LO_BASE  = 38'h00_5000_0000;
    localparam logic [37:0] CCI_UNC_LO_TOP   = 38'h00_7fff_ffff;
    localparam logic [37:0] CCI_UNC_HI_BASE  = 38'h10_0000_0000;
    localparam logic [37:0] CCI_UNC_HI_TOP   = 38'h1f_ffff_ffff;
    localparam logic [37:0] CCI_MEM_LO_BASE  = 38'h00_8000_0000;
    localparam logic [37:0] CCI_MEM_LO_TOP   = 38'h00_ffff_ffff;
    localparam logic [37:0] CCI_MEM_HI_BASE  = 38'h20_0000_0000;
    localparam logic [37:0] CCI_MEM_HI_TOP   = 38'h3f_ffff_ffff;
    localparam logic [37:0] CCI_TDR_BASE     = 38'h00_0100_0000; // Tight data RAM, 8 KiB.
    localparam logic [37:0] CCI_TDR_TOP      = 38'h00_0100_1fff;
    localparam logic [37:0] CCI_TIR_BASE     = 38'h00_0180_0000; // Tight instruction RAM space.
    localparam logic [37:0] CCI_TIR_TOP      = 38'h00_0182_6fff;
    // Inbound routing target.
    typedef enum logic [2:0] {
        CCI_RT_NONE  = 3'b000,
        CCI_RT_LOCAL = 3'b001,
        CCI_RT_PER   = 3'b010,
        CCI_RT_UNC   = 3'b011,
        CCI_RT_MEM   = 3'b100
    } cci_route_e;
    // Host reset sequencer states.
    typedef enum logic [1:0] {
        CCI_HS_HOLD = 2'b00,
        CCI_HS_RUN  = 2'b01
    } cci_hstate_e;
endpackage

/* inc/cci_if.sv */
// Boundary wires between the core complex and its integrating system.
// Assumes one system clock feeds both modports.
`timescale 1ns/10ps
interface cci_if;
    import cci_pkg::*;
    logic                    sys_reset;           // Active-high synchronous reset.
    logic [CCI_ADDR_W-1:0]   boot_addr;           // Boot address.
    logic                    realtime_tick_in;    // Real-time tick level.
    logic [CCI_HARTS*CCI_LIRQ_W-1:0] local_irq;   // Local interrupt levels, hart-major.
    logic [CCI_GIRQ_W-1:0]   global_irq;          // Global interrupt levels.
    logic                    in_valid;            // Inbound bus request strobe.
    logic                    in_write;            // Inbound write when high.
    logic [CCI_ADDR_W-1:0]   in_addr;             // Inbound address.
    logic [CCI_NARROW_W-1:0] in_wdata;            // Inbound write data.
    logic                    in_resp;             // Inbound answer strobe.
    logic [CCI_NARROW_W-1:0] in_rdata;            // Inbound read data.
    logic                    in_err;              // Inbound access hit no target.
    logic                    per_valid;           // Peripheral outbound strobe.
    logic                    unc_valid;           // Uncached outbound strobe.
    logic                    mem_valid;           // Cacheable outbound strobe.
    logic                    out_write;           // Outbound write flag.
    logic [CCI_ADDR_W-1:0]   out_addr;            // Outbound address.
    logic [CCI_WIDE_W-1:0]   out_wdata;           // Outbound data, narrow ports use low half.
    logic [CCI_HARTS:0]      halt_err;            // Fatal-error levels, top bit is level-2 cache.
    logic [CCI_HARTS-1:0]    ecc_multi_err;       // Host error injection per hart.
    logic                    l2_multi_err;        // Host error injection for the cache.
    logic                    dbg_test_mode;       // Debug test mode.
    logic                    dbg_test_reset;      // Debug test-mode reset.
    modport device (
        input  sys_reset, boot_addr, realtime_tick_in, local_irq, global_irq,
        input  in_valid, in_write, in_addr, in_wdata, ecc_multi_err, l2_multi_err,
        input  dbg_test_mode, dbg_test_reset,
        output in_resp, in_rdata, in_err, per_valid, unc_valid, mem_valid,
        output out_write, out_addr, out_wdata, halt_err
    );
    modport host (
        output sys_reset, boot_addr, realtime_tick_in, local_irq, global_irq,
        output in_valid, in_write, in_addr, in_wdata, ecc_multi_err, l2_multi_err,
        output dbg_test_mode, dbg_test_reset,
        input  in_resp, in_rdata, in_err, per_valid, unc_valid, mem_valid,
        input  out_write, out_addr, out_wdata, halt_err
    );
endinterface

/* verilog/cci_device.sv */
// Core complex boundary: reset handling, real-time counter, inbound routing,
// fatal-error latches and debug reset selection.
// Assumes all inputs synchronous to i_clock, the system clock.
`timescale 1ns/10ps
module cci_device
    import cci_pkg::*;
(
    input  wire logic                    i_clock,         // System clock.
    input  wire logic                    i_rst_n,         // Asynchronous power-on reset, active low.
    input  wire logic                    i_clk_en,        // Freezes all state while low.
    cci_if.device                        bus,             // Boundary toward the system.
    output logic [CCI_MTIME_W-1:0]       o_mtime,         // Real-time counter value.
    output logic [CCI_HARTS-1:0]         o_fetch_start,   // One-cycle start pulse per hart.
    output logic [CCI_ADDR_W-1:0]        o_fetch_addr,    // First fetch address.
    output logic                         o_dbg_reset,     // Internal debug reset, active high.
    output logic                         o_icache_reconf, // Reconfiguration request pulse.
    output logic [CCI_HARTS-1:0]         o_lirq_pend,     // Any local interrupt pending per hart.
    output logic                         o_girq_pend,     // Any global interrupt pending.
    output logic [CCI_GIRQ_TOTAL-1:0]    o_girq_src       // All controller sources.
);
    // Reset path: a two-stage synchroniser on the synchronous reset.
    logic rst_meta_reg;            // First stage, read only by the second.
    logic rst_sync_reg;            // Second stage.
    logic core_rst;                // Effective internal reset.
    logic rst_prev_reg;            // Previous internal reset for release detection.
    // Tick synchroniser and edge detect.
    logic tick_meta_reg;           // First stage.
    logic tick_sync_reg;           // Second stage.
    logic tick_prev_reg;           // Delayed copy for the edge.
    logic tick_rise;               // Rising edge of the synchronised tick.
    // Routing decode.
    cci_route_e route;             // Target of the current inbound request.
    logic hit_per;                 // Peripheral window hit.
    logic hit_unc;                 // Uncached window hit.
    logic hit_mem;                 // Cacheable window hit.
    logic hit_tdr;                 // Tight data RAM hit.
    logic hit_tir;                 // Tight instruction RAM space hit.
    logic [CCI_ADDR_W-1:0] a;      // Shorthand for the inbound address.
    // Local tight data RAM, small model of 8 KiB as 1 K doublewords.
    logic [CCI_NARROW_W-1:0] tdr_mem [0:1023];
    logic [9:0] tdr_idx;           // Doubleword index into the RAM.

    // In test mode the synchroniser is skipped so scan sees reset at once.
    assign core_rst = bus.dbg_test_mode ? bus.sys_reset : rst_sync_reg;
    assign tick_rise = tick_sync_reg & ~tick_prev_reg;
    assign a = bus.in_addr;
    assign hit_per = ((a >= CCI_PER_LO_BASE) && (a <= CCI_PER_LO_TOP)) ||
                     ((a >= CCI_PER_HI_BASE) && (a <= CCI_PER_HI_TOP));
    assign hit_unc = ((a >= CCI_UNC_LO_BASE) && (a <= CCI_UNC_LO_TOP)) ||
                     ((a >= CCI_UNC_HI_BASE) && (a <= CCI_UNC_HI_TOP));
    assign hit_mem = ((a >= CCI_MEM_LO_BASE) && (a <= CCI_MEM_LO_TOP)) ||
                     ((a >= CCI_MEM_HI_BASE) && (a <= CCI_MEM_HI_TOP));
    assign hit_tdr = (a >= CCI_TDR_BASE) && (a <= CCI_TDR_TOP);
    assign hit_tir = (a >= CCI_TIR_BASE) && (a <= CCI_TIR_TOP);
    assign tdr_idx = a[12:3];
    // Address decoding as a priority chain; no protection check is applied.
    always_comb begin
        if (hit_tdr || hit_tir) begin
            route = CCI_RT_LOCAL;
        end else if (hit_per) begin
            route = CCI_RT_PER;
        end else if (hit_unc) begin
            route = CCI_RT_UNC;
        end else if (hit_mem) begin
            route = CCI_RT_MEM;
        end else begin
            route = CCI_RT_NONE;
        end
    end

    // Reset synchroniser, on the system clock like all port logic.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= 1'b1;
        end else if (i_clk_en) begin
            rst_meta_reg <= bus.sys_reset;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Debug reset follows the test reset only in test mode, else the core reset.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dbg_reset <= 1'b1;
        end else if (i_clk_en) begin
            o_dbg_reset <= bus.dbg_test_mode ? bus.dbg_test_reset : core_rst;
        end
    end

    // Tick synchroniser and real-time counter.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_meta_reg <= 1'b0;
            tick_sync_reg <= 1'b0;
            tick_prev_reg <= 1'b0;
            o_mtime       <= '0;
        end else if (i_clk_en) begin
            tick_meta_reg <= bus.realtime_tick_in;
            tick_sync_reg <= tick_meta_reg;
            tick_prev_reg <= tick_sync_reg;
            if (core_rst) begin
                o_mtime <= '0;
            end else if (tick_rise) begin
                o_mtime <= o_mtime + 64'h1;
            end
        end
    end

    // Fetch start: one pulse per hart on the first cycle out of reset.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_prev_reg  <= 1'b1;
            o_fetch_start <= '0;
            o_fetch_addr  <= '0;
        end else if (i_clk_en) begin
            rst_prev_reg  <= core_rst;
            o_fetch_start <= (rst_prev_reg && !core_rst) ? '1 : '0;
            if (rst_prev_reg && !core_rst) begin
                o_fetch_addr <= bus.boot_addr;
            end
        end
    end

    // Fatal-error latches: set on a multi-bit error, cleared only by reset.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.halt_err <= '0;
        end else if (i_clk_en) begin
            if (core_rst) begin
                bus.halt_err <= '0;
            end else begin
                bus.halt_err <= bus.halt_err | {bus.l2_multi_err, bus.ecc_multi_err};
            end
        end
    end

    // Interrupt level registers; lines are sampled as levels each cycle.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_lirq_pend <= '0;
            o_girq_pend <= 1'b0;
            o_girq_src  <= '0;
        end else if (i_clk_en) begin
            for (int h = 0; h < CCI_HARTS; h++) begin
                o_lirq_pend[h] <= |bus.local_irq[h*CCI_LIRQ_W +: CCI_LIRQ_W];
            end
            o_girq_pend <= |bus.global_irq;
            // Top sources are internal; only the cache error is wired here.
            o_girq_src  <= {2'b00, bus.halt_err[CCI_HARTS], bus.global_irq};
        end
    end

    // Tight data RAM: written by inbound traffic, no reset on the array.
    always_ff @(posedge i_clock) begin
        if (i_clk_en && bus.in_valid && bus.in_write && hit_tdr && !core_rst) begin
            tdr_mem[tdr_idx] <= bus.in_wdata;
        end
    end

    // Inbound answer and outbound forwarding, one cycle after the request.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.in_resp     <= 1'b0;
            bus.in_rdata    <= '0;
            bus.in_err      <= 1'b0;
            bus.per_valid   <= 1'b0;
            bus.unc_valid   <= 1'b0;
            bus.mem_valid   <= 1'b0;
            bus.out_write   <= 1'b0;
            bus.out_addr    <= '0;
            bus.out_wdata   <= '0;
            o_icache_reconf <= 1'b0;
        end else if (i_clk_en) begin
            bus.in_resp     <= bus.in_valid && !core_rst;
            bus.in_err      <= bus.in_valid && !core_rst && (route == CCI_RT_NONE);
            bus.in_rdata    <= (hit_tdr && !bus.in_write) ? tdr_mem[tdr_idx] : '0;
            bus.per_valid   <= bus.in_valid && !core_rst && (route == CCI_RT_PER);
            bus.unc_valid   <= bus.in_valid && !core_rst && (route == CCI_RT_UNC);
            bus.mem_valid   <= bus.in_valid && !core_rst && (route == CCI_RT_MEM);
            bus.out_write   <= bus.in_write;
            bus.out_addr    <= bus.in_addr;
            bus.out_wdata   <= {64'h0, bus.in_wdata};
            // A write into the instruction RAM space requests reconfiguration.
            o_icache_reconf <= bus.in_valid && bus.in_write && hit_tir && !core_rst;
        end
    end
endmodule

/* verilog/cci_host.sv */
// Integrating system end: reset sequencing, boot address, real-time tick
// and a single-request inbound master driven from a user port.
// Assumes one system clock shared with the device.
`timescale 1ns/10ps
module cci_host
    import cci_pkg::*;
(
    input  wire logic                    i_clock,        // System clock.
    input  wire logic                    i_rst_n,        // Asynchronous reset, active low.
    input  wire logic                    i_clk_en,       // Freezes all state while low.
    cci_if.host                          bus,            // Boundary toward the device.
    input  wire logic                    i_req,          // User request pulse.
    input  wire logic                    i_req_write,    // Write when high.
    input  wire logic [CCI_ADDR_W-1:0]   i_req_addr,     // Request address.
    input  wire logic [CCI_NARROW_W-1:0] i_req_wdata,    // Request data.
    input  wire logic [CCI_HARTS*CCI_LIRQ_W-1:0] i_local_irq, // Local interrupt levels.
    input  wire logic [CCI_GIRQ_W-1:0]   i_global_irq,   // Global interrupt levels.
    input  wire logic [CCI_HARTS-1:0]    i_ecc_err,      // Hart error injection.
    input  wire logic                    i_l2_err,       // Cache error injection.
    input  wire logic                    i_test_mode,    // Debug test mode.
    input  wire logic                    i_test_reset,   // Debug test reset.
    output logic                         o_ready,        // Reset done and no request open.
    output logic                         o_resp,         // Answer pulse.
    output logic [CCI_NARROW_W-1:0]      o_rdata,        // Answer data.
    output logic                         o_err,          // Answer error.
    output logic [CCI_HARTS:0]           o_halt          // Copy of fatal-error levels.
);
    cci_hstate_e state_reg;            // Reset sequencer state.
    logic [4:0]  rst_cnt_reg;          // Reset hold counter.
    logic [2:0]  tick_cnt_reg;         // Tick half-period counter.
    logic        busy_reg;             // A request is open.
    logic        rst_done;             // Hold count reached.
    logic        tick_wrap;            // Half period elapsed.

    assign rst_done  = (rst_cnt_reg == 5'(CCI_RST_CYCLES - 1));
    assign tick_wrap = (tick_cnt_reg == 3'(CCI_TICK_DIV - 1));

    // Reset sequencer: hold reset 16 cycles, then release on a clock edge.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg     <= CCI_HS_HOLD;
            rst_cnt_reg   <= '0;
            bus.sys_reset <= 1'b1;
        end else if (i_clk_en) begin
            case (state_reg)
                CCI_HS_HOLD: begin
                    rst_cnt_reg <= rst_cnt_reg + 5'h1;
                    if (rst_done) begin
                        state_reg     <= CCI_HS_RUN;
                        bus.sys_reset <= 1'b0;
                    end
                end
                default: begin
                    bus.sys_reset <= 1'b0;
                end
            endcase
        end
    end

    // Real-time tick: constant rate well below half the system clock.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt_reg         <= '0;
            bus.realtime_tick_in <= 1'b0;
        end else if (i_clk_en) begin
            tick_cnt_reg <= tick_wrap ? 3'h0 : tick_cnt_reg + 3'h1;
            if (tick_wrap) begin
                bus.realtime_tick_in <= ~bus.realtime_tick_in;
            end
        end
    end

    // Level inputs registered onto the boundary, synchronous to the clock.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.boot_addr      <= '0;
            bus.local_irq      <= '0;
            bus.global_irq     <= '0;
            bus.ecc_multi_err  <= '0;
            bus.l2_multi_err   <= 1'b0;
            bus.dbg_test_mode  <= 1'b0;
            bus.dbg_test_reset <= 1'b0;
            o_halt             <= '0;
        end else if (i_clk_en) begin
            bus.boot_addr      <= 38'(CCI_BOOT_ADDR);
            bus.local_irq      <= i_local_irq;
            bus.global_irq     <= i_global_irq;
            bus.ecc_multi_err  <= i_ecc_err;
            bus.l2_multi_err   <= i_l2_err;
            bus.dbg_test_mode  <= i_test_mode;
            bus.dbg_test_reset <= i_test_reset;
            o_halt             <= bus.halt_err;
        end
    end

    // Inbound master: one request at a time, waits for the answer.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_reg     <= 1'b0;
            bus.in_valid <= 1'b0;
            bus.in_write <= 1'b0;
            bus.in_addr  <= '0;
            bus.in_wdata <= '0;
            o_ready      <= 1'b0;
            o_resp       <= 1'b0;
            o_rdata      <= '0;
            o_err        <= 1'b0;
        end else if (i_clk_en) begin
            bus.in_valid <= 1'b0;
            o_resp       <= bus.in_resp;
            o_rdata      <= bus.in_rdata;
            o_err        <= bus.in_err;
            if (busy_reg && bus.in_resp) begin
                busy_reg <= 1'b0;
            end else if (!busy_reg && i_req && o_ready) begin
                busy_reg     <= 1'b1;
                bus.in_valid <= 1'b1;
                bus.in_write <= i_req_write;
                bus.in_addr  <= i_req_addr;
                bus.in_wdata <= i_req_wdata;
            end
            o_ready <= (state_reg == CCI_HS_RUN) && !busy_reg && !(i_req && o_ready);
        end
    end
endmodule

/* bench/cci_props.sv */
// Checker for the wires between the core complex and its host.
// Assumes one system clock and the bench's active-low reset.
`timescale 1ns/10ps
module cci_props
    import cci_pkg::*;
(
    input wire logic                  i_clock,
    input wire logic                  i_rst_n,
    input wire logic                  sys_reset,
    input wire logic                  in_valid,
    input wire logic [CCI_ADDR_W-1:0] in_addr,
    input wire logic                  in_resp,
    input wire logic                  in_err,
    input wire logic                  per_valid,
    input wire logic                  unc_valid,
    input wire logic                  mem_valid,
    input wire logic [CCI_ADDR_W-1:0] out_addr,
    input wire logic [CCI_HARTS:0]    halt_err,
    input wire logic [CCI_HARTS-1:0]  ecc_multi_err
);
    // Window hits as {cacheable, uncached, peripheral}.
    function automatic logic [2:0] win(input logic [37:0] a);
        return {(a >= CCI_MEM_LO_BASE && a <= CCI_MEM_LO_TOP) || (a >= CCI_MEM_HI_BASE && a <= CCI_MEM_HI_TOP),
                (a >= CCI_UNC_LO_BASE && a <= CCI_UNC_LO_TOP) || (a >= CCI_UNC_HI_BASE && a <= CCI_UNC_HI_TOP),
                (a >= CCI_PER_LO_BASE && a <= CCI_PER_LO_TOP) || (a >= CCI_PER_HI_BASE && a <= CCI_PER_HI_TOP)};
    endfunction
    wire [2:0] out_w = win(out_addr); // Window of the forwarded address.
    wire [2:0] in_w  = win(in_addr);  // Window of the inbound address.
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    resp_after_req_a: assert property (in_valid |=> in_resp) else $error("no answer to request");
    resp_cause_a: assert property (in_resp |-> $past(in_valid)) else $error("answer without request");
    per_window_a: assert property (per_valid |-> out_w[0]) else $error("peripheral outside window");
    unc_window_a: assert property (unc_valid |-> out_w[1]) else $error("uncached outside window");
    mem_window_a: assert property (mem_valid |-> out_w[2]) else $error("cacheable outside window");
    forward_hit_a: assert property (in_valid && in_w != 3'h0 |=> {mem_valid, unc_valid, per_valid} == $past(in_w)
        && !in_err) else $error("window hit not forwarded");
    err_raise_a: assert property (!sys_reset && ecc_multi_err != 5'h0 |=> (halt_err[4:0] & $past(ecc_multi_err))
        == $past(ecc_multi_err)) else $error("fatal error not raised");
    err_sticky_a: assert property ((|($past(halt_err) & ~halt_err)) |-> $past(sys_reset) || $past(sys_reset, 2)
        || $past(sys_reset, 3) || $past(sys_reset, 4)) else $error("fatal error dropped");
    cover property (per_valid);
    cover property (in_resp && in_err);
    cover property (halt_err[5]);
endmodule

/* bench/tb_core_complex_top_interface.sv */
// Bench joining both ends through the interface; drives the host's user side.
// Assumes the package constants and the host's default boot address.
`timescale 1ns/10ps
module tb_core_complex_top_interface;
    import cci_pkg::*;
    logic i_clock = 0, i_rst_n = 0, req = 0, wr = 0, tm = 0, tr = 0, l2e = 0, rerr, err, ready, resp, dbg, rcf, gp;
    logic [37:0] addr = '0, fa;
    logic [63:0] wd = '0, rd, rdata, mt, t0;
    logic [239:0] lirq = '0;
    logic [507:0] girq = '0;
    logic [510:0] gsrc;
    logic [4:0] ecc = '0, lp, fs;
    logic [5:0] halt;
    int errors = 0, checks_done = 0, rcf_n = 0;
    logic [37:0] tab [7] = '{38'h00_2000_0000, 38'h01_0000_0000, 38'h00_5000_0000, 38'h10_0000_0000,
                             38'h00_8000_0008, 38'h3f_ffff_fff8, 38'h00_0000_2000};
    always #5 i_clock = ~i_clock;
    // Counted mid-cycle so the pulse is read where it is settled.
    always @(negedge i_clock) if (rcf === 1'b1) rcf_n++;
    cci_if bus_if();
    cci_device cci_device_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(1'b1), .bus(bus_if), .o_mtime(mt),
        .o_fetch_start(fs), .o_fetch_addr(fa), .o_dbg_reset(dbg), .o_icache_reconf(rcf), .o_lirq_pend(lp),
        .o_girq_pend(gp), .o_girq_src(gsrc));
    cci_host cci_host_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(1'b1), .bus(bus_if), .i_req(req),
        .i_req_write(wr), .i_req_addr(addr), .i_req_wdata(wd), .i_local_irq(lirq), .i_global_irq(girq),
        .i_ecc_err(ecc), .i_l2_err(l2e), .i_test_mode(tm), .i_test_reset(tr), .o_ready(ready), .o_resp(resp),
        .o_rdata(rd), .o_err(err), .o_halt(halt));
    cci_props cci_props_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .sys_reset(bus_if.sys_reset),
        .in_valid(bus_if.in_valid), .in_addr(bus_if.in_addr), .in_resp(bus_if.in_resp), .in_err(bus_if.in_err),
        .per_valid(bus_if.per_valid), .unc_valid(bus_if.unc_valid), .mem_valid(bus_if.mem_valid),
        .out_addr(bus_if.out_addr), .halt_err(bus_if.halt_err), .ecc_multi_err(bus_if.ecc_multi_err));
    // Compares one value bit for bit; an unknown matches only an unknown.
    task automatic chk(input logic [127:0] s, input logic [127:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One inbound access; the request is raised only while the host is ready.
    task automatic acc(input logic w, input logic [37:0] a, input logic [63:0] d);
        @(negedge i_clock);
        {req, wr, addr, wd} = {1'b1, w, a, d};
        @(negedge i_clock);
        req = 1'b0;
        while (resp !== 1'b1) @(negedge i_clock);
        {rdata, rerr} = {rd, err};
        while (ready !== 1'b1) @(negedge i_clock);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Hangs are cut at many times the expected run length.
    initial begin
        #50000;
        errors++;
        summarize;
    end
    initial begin
        repeat (5) @(negedge i_clock);
        i_rst_n = 1'b1;
        while (ready !== 1'b1) @(negedge i_clock);
        // The device leaves reset two edges after the host, so the start pulse comes later.
        repeat (2) @(negedge i_clock);
        chk(fs, 5'h1f);
        chk(fa, 38'(CCI_BOOT_ADDR));
        @(negedge i_clock);
        chk(fs, 5'h00);
        acc(1'b1, 38'h00_0100_0008, 64'h0123_4567_89ab_cdef);
        acc(1'b0, 38'h00_0100_0008, 64'h0);
        chk(rdata, 64'h0123_4567_89ab_cdef);
        acc(1'b1, 38'h00_0180_0000, 64'h1);
        chk(rcf_n, 1);
        for (int k = 0; k < 7; k++) begin
            acc(1'b0, tab[k], 64'h0);
            chk(rerr, k == 6);
        end
        $display("test bus done");
        t0 = mt;
        repeat (80) @(negedge i_clock);
        chk(mt, t0 + 64'd10);
        ecc = 5'h04;
        l2e = 1'b1;
        @(negedge i_clock);
        {ecc, l2e} = 6'h0;
        repeat (6) @(negedge i_clock);
        chk(halt, 6'h24);
        repeat (20) @(negedge i_clock);
        chk(halt, 6'h24);
        lirq[3*48+7] = 1'b1;
        girq[507] = 1'b1;
        repeat (4) @(negedge i_clock);
        chk(lp, 5'h08);
        chk({gp, gsrc[510:507]}, 5'h13);
        tr = 1'b1;
        repeat (4) @(negedge i_clock);
        chk(dbg, 1'b0);
        tm = 1'b1;
        repeat (4) @(negedge i_clock);
        chk(dbg, 1'b1);
        tr = 1'b0;
        repeat (4) @(negedge i_clock);
        chk(dbg, 1'b0);
        // A short reset in test mode: with the synchroniser skipped the start pulse comes with ready.
        i_rst_n = 1'b0;
        @(negedge i_clock);
        i_rst_n = 1'b1;
        while (ready !== 1'b1) @(negedge i_clock);
        chk(fs, 5'h1f);
        chk(halt, 6'h00);
        $display("test side done");
        summarize;
    end
endmodule
